// ### hw/sct_top.sv
`timescale 1ns/10ps
module sct_top
    import sct_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SCT_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // low-speed oscillator pin
    input wire logic osc_clk,
    // level request to the interrupt controller
    output logic irq_req
);

    sct_top_s q; // registered state
    sct_top_s d; // next state

    // bus phases
    logic setup; // first cycle of a transfer
    logic access; // second cycle, completes at once
    logic wr; // write completes this edge

    // address decode
    logic hit_div;
    logic hit_ctl;
    logic hit_cnt;
    logic hit_cmp;
    logic hit_msk;
    logic hit_flg;
    logic mapped; // any register hit

    // timer events
    logic tick; // divided count strobe
    logic clr_wr; // software counter clear
    logic step; // counter advances this cycle
    logic match; // counter equals match value on a step
    logic flg_clr; // software write-one to the flag

    // divided, gated count strobe
    sct_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .osc_clk(osc_clk),
        .gate_en(q.gate),
        .div_sel(q.sel),
        .tick(tick)
    );

    // phase decode; the slave never inserts wait states, so every
    // access phase is also the completing one and the master needs
    // no retry path
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;

    // each register is one aligned word at four times its index;
    // the full address is compared, so aliases never hit a register
    assign hit_div = (paddr == `SCT_ADDR(`SCT_IDX_DIV));
    assign hit_ctl = (paddr == `SCT_ADDR(`SCT_IDX_CTL));
    assign hit_cnt = (paddr == `SCT_ADDR(`SCT_IDX_CNT));
    assign hit_cmp = (paddr == `SCT_ADDR(`SCT_IDX_CMP));
    assign hit_msk = (paddr == `SCT_ADDR(`SCT_IDX_MSK));
    assign hit_flg = (paddr == `SCT_ADDR(`SCT_IDX_FLG));
    assign mapped = hit_div | hit_ctl | hit_cnt | hit_cmp | hit_msk | hit_flg;

    // clear is a pure strobe, nothing is stored for it
    assign clr_wr = wr & hit_ctl & pwdata[`SCT_CTL_CLR];

    // the strobe only counts while running; a software clear in the
    // same cycle swallows the strobe, so a run-and-clear write always
    // restarts from zero rather than one
    assign step = tick & (q.run == SCT_RUN) & ~clr_wr;

    // compare happens on a step; the clear lands on that same step,
    // so the match value stays visible for a whole count period
    assign match = step & (q.cnt == q.cmp);

    // write of one to the flag bit clears it
    assign flg_clr = wr & hit_flg & pwdata[`SCT_IRQ_BIT];

    // next-state logic for registers, counter and bus answer
    always_comb begin
        d = q;

        // control register: run and mode are stored; mode changes are
        // only meaningful while stopped, nothing here guards against it
        if (wr && hit_ctl) begin
            d.run = sct_run_e'(pwdata[`SCT_CTL_RUN]);
            d.mode = pwdata[`SCT_CTL_MODE];
        end

        // match value register
        if (wr && hit_cmp) begin
            d.cmp = pwdata[`SCT_BYTE];
        end

        // interrupt enable register
        if (wr && hit_msk) begin
            d.ie = pwdata[`SCT_IRQ_BIT];
        end

        // divider control; changes are only safe while stopped
        if (wr && hit_div) begin
            d.sel = pwdata[`SCT_DIV_SEL];
            d.gate = pwdata[`SCT_DIV_EN];
        end

        // writes to the count register fall through untouched
        // counter: software clear beats any step; the match test only
        // looks at stepping cycles, so a stopped counter never matches
        if (clr_wr) begin
            // with run also written, counting restarts from zero
            d.cnt = `SCT_CNT_RST;
        end else if (match) begin
            d.cnt = `SCT_CNT_RST;
            if (q.mode) begin
                // one-shot: cleared and stopped on the same edge
                d.run = SCT_STOP;
            end
            // repeat mode keeps run set and wraps to zero
        end else if (step) begin
            d.cnt = q.cnt + 8'h01;
        end

        // flag: hardware set wins over a clear in the same cycle
        if (flg_clr) begin
            d.flag = 1'b0;
        end
        if (match && q.ie) begin
            d.flag = 1'b1;
        end

        // read data and error are captured in the setup cycle; the
        // word is frozen for the access phase, so a count that steps
        // between the two phases still returns one consistent value
        if (setup) begin
            d.err = ~mapped;
            d.rdata = `SCT_ZERO32;
            if (hit_ctl) begin
                // clear bit is write-only and reads zero
                d.rdata[`SCT_CTL_RUN] = q.run;
                d.rdata[`SCT_CTL_MODE] = q.mode;
            end else if (hit_cnt) begin
                d.rdata[`SCT_BYTE] = q.cnt;
            end else if (hit_cmp) begin
                d.rdata[`SCT_BYTE] = q.cmp;
            end else if (hit_msk) begin
                d.rdata[`SCT_IRQ_BIT] = q.ie;
            end else if (hit_flg) begin
                d.rdata[`SCT_IRQ_BIT] = q.flag;
            end else if (hit_div) begin
                d.rdata[`SCT_DIV_SEL] = q.sel;
                d.rdata[`SCT_DIV_EN] = q.gate;
            end
        end
    end

    // state register with defined reset values; the reset branch
    // assigns constants only, so no reset path depends on logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.cnt <= `SCT_CNT_RST;
            q.cmp <= `SCT_CMP_RST;
            q.run <= SCT_STOP;
            q.mode <= 1'b0;
            q.sel <= `SCT_SEL_RST;
            q.gate <= 1'b0;
            q.ie <= 1'b0;
            q.flag <= 1'b0;
            q.rdata <= `SCT_ZERO32;
            q.err <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // bus outputs; read data comes straight from a flop
    // and the error is qualified by the access phase alone
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = access & q.err;

    // the request is a level that lasts as long as the flag;
    // the controller must treat it as level triggered
    assign irq_req = q.flag;

    // ------------------------------------------------------------
    // checks
    // all properties sample on the bus clock and pause in reset
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // software clear zeroes the counter on the next edge
    clear_counter_a: assert property (
        clr_wr |=> q.cnt == `SCT_CNT_RST)
        else $error("counter not cleared by write");

    // stopped counter keeps its value
    stop_holds_a: assert property (
        q.run == SCT_STOP && !clr_wr |=> q.cnt == $past(q.cnt))
        else $error("stopped counter moved");

    // a step below the match value adds exactly one
    count_up_a: assert property (
        step && q.cnt != q.cmp |=> q.cnt == $past(q.cnt) + 8'h01)
        else $error("counter did not advance by one");

    // repeat mode wraps to zero and keeps running
    repeat_wrap_a: assert property (
        match && !q.mode && !(wr && hit_ctl)
        |=> q.cnt == `SCT_CNT_RST && q.run == SCT_RUN)
        else $error("repeat mode did not wrap");

    // one-shot mode clears and stops
    oneshot_stop_a: assert property (
        match && q.mode |=> q.cnt == `SCT_CNT_RST && q.run == SCT_STOP)
        else $error("one-shot did not stop");

    // run plus clear in one write starts from zero and runs
    run_clear_a: assert property (
        clr_wr && pwdata[`SCT_CTL_RUN]
        |=> q.cnt == `SCT_CNT_RST && q.run == SCT_RUN)
        else $error("run with clear misbehaved");

    // an enabled match raises the request on the next edge
    flag_set_a: assert property (
        match && q.ie |=> q.flag ##0 irq_req)
        else $error("enabled match did not set flag");

    // a masked match leaves the flag alone
    flag_masked_a: assert property (
        !q.flag && !(match && q.ie) |=> !q.flag)
        else $error("flag set without enabled match");

    // write-one clears the flag unless a new match arrives
    flag_w1c_a: assert property (
        flg_clr && !(match && q.ie) |=> !q.flag && !irq_req)
        else $error("flag not cleared by write one");

    // zero writes do not clear
    flag_keep_a: assert property (
        q.flag && !flg_clr |=> q.flag)
        else $error("flag dropped without write one");

    // request follows the flag while set
    irq_level_a: assert property (
        q.flag && !flg_clr |=> irq_req [*1] ##1 1'b1)
        else $error("request not held as a level");

    // clear bit reads back as zero
    clr_reads_zero_a: assert property (
        setup && hit_ctl |=> !prdata[`SCT_CTL_CLR])
        else $error("clear bit read as one");

    // count register ignores writes
    cnt_readonly_a: assert property (
        wr && hit_cnt && !step |=> q.cnt == $past(q.cnt))
        else $error("count register took a write");

    // match value resets to zero and loads on write
    cmp_load_a: assert property (
        wr && hit_cmp |=> q.cmp == $past(pwdata[`SCT_BYTE]))
        else $error("match value not loaded");

    // the match value only moves on a write to its register
    cmp_hold_a: assert property (
        !(wr && hit_cmp) |=> q.cmp == $past(q.cmp))
        else $error("match value changed without a write");

    // enable bit loads from the written word
    mask_load_a: assert property (
        wr && hit_msk |=> q.ie == $past(pwdata[`SCT_IRQ_BIT]))
        else $error("enable bit not loaded");

    // mode bit loads from the control write
    mode_load_a: assert property (
        wr && hit_ctl |=> q.mode == $past(pwdata[`SCT_CTL_MODE]))
        else $error("mode bit not loaded");

    // run bit loads unless a one-shot match stops it at once
    run_load_a: assert property (
        wr && hit_ctl && !(match && q.mode)
        |=> (q.run == SCT_RUN) == $past(pwdata[`SCT_CTL_RUN]))
        else $error("run bit not loaded");

    // divider select loads from the written word
    sel_load_a: assert property (
        wr && hit_div |=> q.sel == $past(pwdata[`SCT_DIV_SEL]))
        else $error("divider select not loaded");

    // gate enable loads from the written word
    gate_load_a: assert property (
        wr && hit_div |=> q.gate == $past(pwdata[`SCT_DIV_EN]))
        else $error("gate enable not loaded");

    // a count read returns the value seen at setup
    cnt_read_a: assert property (
        setup && hit_cnt |=> prdata[`SCT_BYTE] == $past(q.cnt))
        else $error("count read back wrong");

    // a match value read returns the stored value
    cmp_read_a: assert property (
        setup && hit_cmp |=> prdata[`SCT_BYTE] == $past(q.cmp))
        else $error("match value read back wrong");

    // a flag read returns the stored flag
    flag_read_a: assert property (
        setup && hit_flg |=> prdata[`SCT_IRQ_BIT] == $past(q.flag))
        else $error("flag read back wrong");

    // a control read returns run and mode
    ctl_read_a: assert property (
        setup && hit_ctl |=> prdata[`SCT_CTL_RUN] == $past(q.run == SCT_RUN)
        && prdata[`SCT_CTL_MODE] == $past(q.mode))
        else $error("control read back wrong");

    // the request only rises after an enabled match
    irq_cause_a: assert property (
        $rose(irq_req) |-> $past(match && q.ie))
        else $error("request rose without enabled match");

    // the request only falls after a write of one
    irq_drop_a: assert property (
        $fell(irq_req) |-> $past(flg_clr))
        else $error("request fell without write one");

    // a match beats a clear that lands in the same cycle
    flag_wins_a: assert property (
        flg_clr && match && q.ie |=> q.flag)
        else $error("clear beat a same-cycle match");

    // one-shot gives a single match per start
    oneshot_once_a: assert property (
        match && q.mode |=> !match)
        else $error("one-shot matched twice");

endmodule : sct_top

// ### pkg/sct_regs.svh
// Functional notes
// - 8-bit up-counter, software clear, readable value
// - repeat mode: match clears, keeps counting
// - one-shot mode: match clears, then stops
// - count clock is oscillator divided 1/1..1/32
// - gate enable bit supplies clock, resets off
// - writing clear bit zeroes counter at once
// - clear bit always reads back zero
// - 8-bit match value, resets to zero
// - match interval is value plus one
// - run bit starts/stops, stop keeps count
// - run plus clear: clear then count
// - match sets flag only when enabled
// - flag drives level request to controller
// - write one clears flag, zero ignored
// - count register is read-only
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

// register indexes; byte address is four times the index
`define SCT_IDX_DIV 18'h05065
`define SCT_IDX_CTL 18'h050c0
`define SCT_IDX_CNT 18'h050c1
`define SCT_IDX_CMP 18'h050c2
`define SCT_IDX_MSK 18'h050c3
`define SCT_IDX_FLG 18'h050c4
`define SCT_ADDR(i) ({(i), 2'b00})
`define SCT_AW 20

// field positions
`define SCT_CTL_RUN 0
`define SCT_CTL_MODE 1
`define SCT_CTL_CLR 4
`define SCT_DIV_EN 0
`define SCT_DIV_SEL 3:1
`define SCT_IRQ_BIT 0
`define SCT_BYTE 7:0

// reset values and limits
`define SCT_CNT_RST 8'h00
`define SCT_CMP_RST 8'h00
`define SCT_SEL_RST 3'h0
`define SCT_SEL_MAX 3'h5
`define SCT_PRE_W 5
`define SCT_ZERO32 32'h0000_0000

`endif

// ### pkg/sct_pkg.sv
package sct_pkg;
`include "sct_regs.svh"

    // run state of the counter
    typedef enum logic {
        SCT_STOP = 1'b0,
        SCT_RUN = 1'b1
    } sct_run_e;

    // divider state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [`SCT_PRE_W-1:0] pre;
        logic tick;
    } sct_div_s;

    // timer and bus state
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] cmp;
        sct_run_e run;
        logic mode;
        logic [2:0] sel;
        logic gate;
        logic ie;
        logic flag;
        logic [31:0] rdata;
        logic err;
    } sct_top_s;

endpackage : sct_pkg

// ### hw/sct_div.sv
`timescale 1ns/10ps
module sct_div
    import sct_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // oscillator pin, asynchronous to pclk
    input wire logic osc_clk,
    // settings
    input wire logic gate_en,
    input wire logic [2:0] div_sel,
    // one-cycle count strobe
    output logic tick
);

    sct_div_s q; // registered state
    sct_div_s d; // next state
    logic [`SCT_PRE_W-1:0] mask; // prescaler bits that must be all ones
    logic rise; // rising edge of the synchronised oscillator

    // mask bit i is set when the ratio needs prescaler bit i
    for (genvar i = 0; i < `SCT_PRE_W; i++) begin : g_mask
        assign mask[i] = (div_sel > 3'(i));
    end

    // edge seen on the second synchroniser flop only
    assign rise = q.sync2 & ~q.prev;

    // next state: synchroniser, prescaler and strobe
    always_comb begin
        d = q;
        d.sync1 = osc_clk;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        d.tick = 1'b0;
        if (!gate_en || div_sel > `SCT_SEL_MAX) begin
            // gated or reserved code: no strobes, prescaler restarts
            d.pre = '0;
        end else if (rise) begin
            d.pre = q.pre + `SCT_PRE_W'(1);
            d.tick = ((q.pre & mask) == mask);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    div_gate_off_a: assert property (!gate_en |=> !tick)
        else $error("count strobe while gate off");
    full_rate_a: assert property (gate_en && div_sel == 3'h0 && rise |=> tick)
        else $error("undivided edge gave no strobe");

endmodule : sct_div

// ### verification/sct_itc_model.sv
`timescale 1ns/10ps
module sct_irq_ctrl_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the timer
    input wire logic irq_req,
    // controller pending bit
    output logic ctrl_pend
);
    // level-triggered input: pending follows the request, never latches
    // a stale edge, so clearing the timer flag withdraws it here too
    logic pend_q;
    // sample the request every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= irq_req;
        end
    end
    assign ctrl_pend = pend_q;
endmodule : sct_irq_ctrl_model

// ### verification/tb_subclock_8bit_compare_timer.sv
`timescale 1ns/10ps
`include "sct_regs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_subclock_8bit_compare_timer;
    // byte addresses of the registers, plus one hole
    localparam logic [19:0] A_DIV = `SCT_ADDR(`SCT_IDX_DIV);
    localparam logic [19:0] A_CTL = `SCT_ADDR(`SCT_IDX_CTL);
    localparam logic [19:0] A_CNT = `SCT_ADDR(`SCT_IDX_CNT);
    localparam logic [19:0] A_CMP = `SCT_ADDR(`SCT_IDX_CMP);
    localparam logic [19:0] A_MSK = `SCT_ADDR(`SCT_IDX_MSK);
    localparam logic [19:0] A_FLG = `SCT_ADDR(`SCT_IDX_FLG);
    localparam logic [19:0] A_BAD = 20'h14320;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [19:0] paddr = 20'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat, c1;
    logic pready, pslverr, rerr, osc_clk = 1'b0, irq_req, ctrl_pend;
    logic [7:0] m;
    logic [2:0] sel;
    int n_mismatch = 0, samples_checked = 0, osc_rises = 0, osc_ph = 0, t0;
    int seed = 32'h48f2fef3;
    sct_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_clk(osc_clk), .irq_req(irq_req));
    sct_irq_ctrl_model u_ctrl (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .ctrl_pend(ctrl_pend));
    // bus clock, 40 ns
    initial begin
        forever #20 pclk = ~pclk;
    end
    // oscillator: 3 cycles high, 3 low, so each level spans at least 2 edges
    always @(posedge pclk) begin
        osc_ph <= (osc_ph == 2) ? 0 : osc_ph + 1;
        if (osc_ph == 2) begin
            osc_clk <= ~osc_clk;
            osc_rises <= osc_rises + (osc_clk ? 0 : 1);
        end
    end
    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic [19:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) n_mismatch++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // read a register and compare it
    task automatic rdc(input logic [19:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK("reg", e, rdat)
    endtask : rdc
    // wait for the request with a bound, sampling off the edge
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 8000) begin
            @(negedge pclk);
            n++;
        end
        `CHK("irq", 1'b1, irq_req)
    endtask : wait_irq
    // verdict and end of run
    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_CMP, 32'h0);
        rdc(A_CTL, 32'h0);
        rdc(A_DIV, 32'h0);
        rdc(A_MSK, 32'h0);
        rdc(A_BAD, 32'h0);
        `CHK("err", 1'b1, rerr)
        // every valid divider code 0..5, random match values, then the 255 corner
        for (int i = 0; i < 7; i++) begin
            sel = (i < 6) ? i[2:0] : 3'h0;
            m = (i < 6) ? 8'(2 + ($random(seed) & 3)) : 8'hff;
            xfer(A_CTL, 1'b1, 32'h0);
            xfer(A_DIV, 1'b1, {28'h0, sel, 1'b1});
            xfer(A_FLG, 1'b1, 32'h1);
            xfer(A_MSK, 1'b1, 32'h1);
            xfer(A_CTL, 1'b1, 32'h10);
            xfer(A_CMP, 1'b1, {24'h0, m});
            xfer(A_CTL, 1'b1, 32'h1);
            wait_irq();
            t0 = osc_rises;
            @(negedge pclk);
            `CHK("pend", 1'b1, ctrl_pend)
            xfer(A_FLG, 1'b1, 32'h0);
            rdc(A_FLG, 32'h1);
            xfer(A_FLG, 1'b1, 32'h1);
            @(negedge pclk);
            `CHK("irq", 1'b0, irq_req)
            @(negedge pclk);
            `CHK("pend", 1'b0, ctrl_pend)
            wait_irq();
            `CHK("period", (int'(m) + 1) << sel, osc_rises - t0)
        end
        // stop keeps the count, count register ignores writes
        xfer(A_CTL, 1'b1, 32'h0);
        xfer(A_CNT, 1'b0, 32'h0);
        c1 = rdat;
        repeat (30) @(posedge pclk);
        rdc(A_CNT, c1);
        xfer(A_CNT, 1'b1, ~c1);
        rdc(A_CNT, c1);
        // run with clear in one write restarts from zero
        xfer(A_CTL, 1'b1, 32'h11);
        rdc(A_CTL, 32'h1);
        repeat (40) @(posedge pclk);
        xfer(A_CTL, 1'b1, 32'h0);
        xfer(A_CNT, 1'b0, 32'h0);
        `CHK("restart", 1'b1, rdat > 0 && rdat < 10)
        xfer(A_CTL, 1'b1, 32'h10);
        rdc(A_CNT, 32'h0);
        // gate off, then a reserved divider code: no counting either way
        for (int k = 0; k < 2; k++) begin
            xfer(A_DIV, 1'b1, k ? 32'hd : 32'h0);
            xfer(A_CTL, 1'b1, 32'h1);
            repeat (60) @(posedge pclk);
            xfer(A_CTL, 1'b1, 32'h0);
            rdc(A_CNT, 32'h0);
        end
        // one-shot with the interrupt masked: stops, flag stays clear
        xfer(A_MSK, 1'b1, 32'h0);
        xfer(A_FLG, 1'b1, 32'h1);
        xfer(A_DIV, 1'b1, 32'h1);
        xfer(A_CMP, 1'b1, 32'h3);
        xfer(A_CTL, 1'b1, 32'h13);
        repeat (200) @(posedge pclk);
        rdc(A_FLG, 32'h0);
        rdc(A_CTL, 32'h2);
        rdc(A_CNT, 32'h0);
        // one-shot unmasked: exactly one match per start
        xfer(A_MSK, 1'b1, 32'h1);
        xfer(A_CTL, 1'b1, 32'h13);
        wait_irq();
        xfer(A_FLG, 1'b1, 32'h1);
        repeat (200) @(posedge pclk);
        @(negedge pclk);
        `CHK("irq", 1'b0, irq_req)
        rdc(A_CTL, 32'h2);
        give_verdict();
    end
endmodule : tb_subclock_8bit_compare_timer
